// ---- verilog/bws_defs.svh ----
// Constants for the board watchdog supervisor: register map, field
// positions, timing figures and strap encodings.
// Assumes a 100 MHz system clock and an ISA I/O bus with 10 address bits.
// Operation
// - Watchdog runs only while the permit strap is installed.
// - Control register decodes at 190h, 290h or 390h per base strap.
// - Any reset leaves the watchdog disabled until software enables it.
// - Missed refresh within the timeout emits a processor reset pulse.
// - Timeout 1.6 s default, 100 ms option, or scaled from a capacitor.
// - Bit 3 reads one while battery good, zero while battery low.
// - With NMI routing, power-fail low drives the channel-check line active.
// - Without NMI routing no NMI; software polls the battery bit.
// - Active-low pushbutton input resets the system.
// - Supply-monitor reset has the same effect as a pushbutton reset.
`ifndef BWS_DEFS_SVH
`define BWS_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define BWS_ADDR_W          10
`define BWS_BASE_0          10'h190
`define BWS_BASE_1          10'h290
`define BWS_BASE_2          10'h390
`define BWS_STRAP_BASE_1    2'h1
`define BWS_STRAP_BASE_2    2'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BWS_BIT_ENABLE      0
`define BWS_BIT_REFRESH     1
`define BWS_BIT_BATT_GOOD   3
`define BWS_DATA_ZERO       8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BWS_CLK_KHZ         100000
`define BWS_TIMEOUT_LONG_MS 1600
`define BWS_TIMEOUT_SHORT_MS 100
`define BWS_CAP_MS_NUM      400
`define BWS_CAP_MS_DEN      47
`define BWS_RST_PULSE_CYC   16

`endif

// ---- verilog/bws_pkg.sv ----
// Types shared by the board watchdog supervisor modules.
// Assumes bws_defs.svh is on the include path.
`include "bws_defs.svh"

package bws_pkg;

    // ----------------------------------------------------------------
    // Bus request as seen by the register decoder
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [9:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } bws_isa_req_t;

    // ----------------------------------------------------------------
    // Software-written control bits
    // ----------------------------------------------------------------
    typedef struct packed {
        logic refresh;
        logic enable;
    } bws_ctrl_t;

    typedef enum logic [2:0] {
        BWS_BUS_IDLE = 3'b001,
        BWS_BUS_WR   = 3'b010,
        BWS_BUS_RD   = 3'b100
    } bws_bus_state_t;

endpackage

// ---- verilog/bws_wdt_timer.sv ----
// Watchdog timeout counter: counts while running, restarts on request,
// pulses expire for one cycle when the count runs out.
// Assumes run and restart are synchronous to sys_clk.
`timescale 1ns/1ns
`include "bws_defs.svh"

module bws_wdt_timer
    import bws_pkg::*;
#(
    parameter longint unsigned TIMEOUT_CYC = 64'd160000000
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // Control
    input  wire logic run,
    input  wire logic restart,
    // Result
    output logic      expire
);

    generate
        if (TIMEOUT_CYC < 64'd2 || TIMEOUT_CYC > 64'hFF_FFFF_FFFF) begin : g_bad
            $error("bws_wdt_timer: timeout count out of range");
        end
    endgenerate

    localparam logic [39:0] LAST = 40'(TIMEOUT_CYC - 64'd1);

    logic [39:0] cnt_reg;
    logic [39:0] cnt_next;
    logic        expire_reg;
    logic        expire_next;

    always_comb begin
        cnt_next    = cnt_reg;
        expire_next = 1'b0;
        if (!run || restart) begin
            cnt_next = '0;
        end else if (cnt_reg == LAST) begin
            // Expiry rearms the count, so expire repeats every timeout while run stays high
            cnt_next    = '0;
            expire_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 40'd1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_reg    <= '0;
            expire_reg <= 1'b0;
        end else begin
            cnt_reg    <= cnt_next;
            expire_reg <= expire_next;
        end
    end

    assign expire = expire_reg;

endmodule

// ---- verilog/bws_reset_merge.sv ----
// Merges pushbutton, supply-monitor and watchdog reset requests into one
// registered active-low system reset; the watchdog pulse is stretched.
// Assumes all request inputs are synchronous to sys_clk.
`timescale 1ns/1ns
`include "bws_defs.svh"

module bws_reset_merge
    import bws_pkg::*;
#(
    parameter int unsigned PULSE_CYC = `BWS_RST_PULSE_CYC
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // Requests
    input  wire logic pushbutton_reset_n,
    input  wire logic supply_reset_n,
    input  wire logic wdt_expire,
    // Result
    output logic      sys_reset_n
);

    generate
        if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_bad
            $error("bws_reset_merge: pulse width out of range");
        end
    endgenerate

    logic [7:0] stretch_reg;
    logic [7:0] stretch_next;
    logic       out_reg;
    logic       out_next;

    always_comb begin
        stretch_next = stretch_reg;
        if (wdt_expire) begin
            stretch_next = 8'(PULSE_CYC);
        end else if (stretch_reg != 8'h00) begin
            stretch_next = stretch_reg - 8'h01;
        end
        // Supply monitor request is treated exactly like the button
        out_next = pushbutton_reset_n
                 & supply_reset_n
                 & (stretch_next == 8'h00);
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            stretch_reg <= 8'h00;
            out_reg     <= 1'b1;
        end else begin
            stretch_reg <= stretch_next;
            out_reg     <= out_next;
        end
    end

    assign sys_reset_n = out_reg;

endmodule

// ---- verilog/bws_top.sv ----
// Board watchdog supervisor: ISA I/O control register, strap capture,
// watchdog enable and refresh, battery status and power-fail NMI routing.
// Assumes ISA strobes and straps are synchronous to sys_clk and that
// sys_reset_n is fed back to rstn by the board reset tree.
`timescale 1ns/1ns
`include "bws_defs.svh"

module bws_top
    import bws_pkg::*;
#(
    parameter longint unsigned TIMEOUT_CYC   =
        64'(`BWS_TIMEOUT_LONG_MS) * 64'(`BWS_CLK_KHZ),
    parameter bit              SHORT_TIMEOUT = 1'b0,
    parameter int unsigned     CAP_PF        = 0,
    parameter int unsigned     PULSE_CYC     = `BWS_RST_PULSE_CYC
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    // ISA I/O bus
    input  wire logic [9:0] isa_addr,
    input  wire logic       isa_aen,
    input  wire logic       isa_iow_n,
    input  wire logic       isa_ior_n,
    input  wire logic [7:0] isa_data_i,
    output logic      [7:0] isa_data_o,
    output logic            isa_data_oe,
    // Channel check line, open drain
    output logic            iochk_n_o,
    output logic            iochk_oe,
    // Straps
    input  wire logic       watchdog_permit_strap,
    input  wire logic [1:0] base_select_strap,
    input  wire logic       nmi_route_strap,
    // Supervisor inputs
    input  wire logic       power_fail_indication_n,
    input  wire logic       pushbutton_reset_n,
    input  wire logic       supply_reset_n,
    // System reset and status
    output logic            sys_reset_n,
    output logic            wdt_active
);

    // ----------------------------------------------------------------
    // Timeout selection
    // ----------------------------------------------------------------
    localparam longint unsigned CAP_MS =
        (64'(CAP_PF) * 64'(`BWS_CAP_MS_NUM)) / 64'(`BWS_CAP_MS_DEN);
    localparam longint unsigned SHORT_CYC =
        64'(`BWS_TIMEOUT_SHORT_MS) * 64'(`BWS_CLK_KHZ);
    localparam longint unsigned EFF_CYC =
        (CAP_PF != 0)  ? CAP_MS * 64'(`BWS_CLK_KHZ) :
        SHORT_TIMEOUT  ? SHORT_CYC : TIMEOUT_CYC;

    generate
        if (CAP_PF != 0 && CAP_MS == 64'd0) begin : g_bad_cap
            $error("bws_top: capacitor value gives a zero timeout");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic [9:0] base_of(input logic [1:0] strap);
        logic [9:0] b;
        b = `BWS_BASE_0;
        if (strap == `BWS_STRAP_BASE_1) begin
            b = `BWS_BASE_1;
        end else if (strap == `BWS_STRAP_BASE_2) begin
            b = `BWS_BASE_2;
        end
        return b;
    endfunction

    function automatic logic hit(input bws_isa_req_t r, input logic [9:0] base);
        return (r.addr == base);
    endfunction

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    // Straps are caught while reset is held, so a jumper moved during
    // operation takes effect only at the next reset.
    logic [1:0] base_strap_reg;
    logic [1:0] base_strap_next;
    logic       permit_reg;
    logic       permit_next;
    logic       nmi_route_reg;
    logic       nmi_route_next;

    always_comb begin
        base_strap_next = base_strap_reg;
        permit_next     = permit_reg;
        nmi_route_next  = nmi_route_reg;
        if (!rstn) begin
            base_strap_next = base_select_strap;
            permit_next     = watchdog_permit_strap;
            nmi_route_next  = nmi_route_strap;
        end
    end

    always_ff @(posedge sys_clk) begin
        base_strap_reg <= base_strap_next;
        permit_reg     <= permit_next;
        nmi_route_reg  <= nmi_route_next;
    end

    // ----------------------------------------------------------------
    // Bus request and strobe state
    // ----------------------------------------------------------------
    bws_isa_req_t   req;
    bws_bus_state_t bus_state_reg;
    bws_bus_state_t bus_state_next;
    logic           sel;
    logic           wr_take;
    logic           rd_take;

    always_comb begin
        req.addr  = isa_addr;
        req.wr    = ~isa_iow_n & ~isa_aen;
        req.rd    = ~isa_ior_n & ~isa_aen;
        req.wdata = isa_data_i;
    end

    assign sel = hit(req, base_of(base_strap_reg));

    // Act once per strobe even though ISA strobes last many clocks
    always_comb begin
        bus_state_next = bus_state_reg;
        wr_take        = 1'b0;
        rd_take        = 1'b0;
        unique case (bus_state_reg)
            BWS_BUS_IDLE: begin
                if (req.wr && sel) begin
                    bus_state_next = BWS_BUS_WR;
                    wr_take        = 1'b1;
                end else if (req.rd && sel) begin
                    bus_state_next = BWS_BUS_RD;
                    rd_take        = 1'b1;
                end
            end
            BWS_BUS_WR: begin
                if (!req.wr) begin
                    bus_state_next = BWS_BUS_IDLE;
                end
            end
            BWS_BUS_RD: begin
                if (!req.rd) begin
                    bus_state_next = BWS_BUS_IDLE;
                end
            end
            default: begin
                bus_state_next = BWS_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            bus_state_reg <= BWS_BUS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    bws_ctrl_t ctrl_reg;
    bws_ctrl_t ctrl_next;
    logic      refresh_hit;
    logic      wdt_run;
    logic      wdt_expire;
    logic      sys_rst_int;

    always_comb begin
        ctrl_next   = ctrl_reg;
        refresh_hit = 1'b0;
        if (!sys_rst_int) begin
            // Our own reset pulse also clears the enable at once
            ctrl_next = '0;
        end else if (wr_take) begin
            ctrl_next.enable  = req.wdata[`BWS_BIT_ENABLE];
            ctrl_next.refresh = req.wdata[`BWS_BIT_REFRESH];
            // Only a change of the refresh bit counts as a refresh
            refresh_hit = (req.wdata[`BWS_BIT_REFRESH] != ctrl_reg.refresh);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Permit strap gates the enable in hardware
    assign wdt_run = ctrl_reg.enable & permit_reg;

    // ----------------------------------------------------------------
    // Watchdog timer and reset merge
    // ----------------------------------------------------------------
    bws_wdt_timer #(
        .TIMEOUT_CYC (EFF_CYC)
    ) u_timer (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .run     (wdt_run),
        .restart (refresh_hit),
        .expire  (wdt_expire)
    );

    bws_reset_merge #(
        .PULSE_CYC (PULSE_CYC)
    ) u_merge (
        .sys_clk            (sys_clk),
        .rstn               (rstn),
        .pushbutton_reset_n (pushbutton_reset_n),
        .supply_reset_n     (supply_reset_n),
        .wdt_expire         (wdt_expire),
        .sys_reset_n        (sys_rst_int)
    );

    assign sys_reset_n = sys_rst_int;

    // ----------------------------------------------------------------
    // Battery status, read data and NMI routing
    // ----------------------------------------------------------------
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       oe_reg;
    logic       oe_next;
    logic       chk_reg;
    logic       chk_next;
    logic       active_reg;
    logic       active_next;

    always_comb begin
        rdata_next = rdata_reg;
        oe_next    = (bus_state_next == BWS_BUS_RD);
        if (rd_take) begin
            rdata_next = `BWS_DATA_ZERO;
            // Control bits read back for diagnostics; software keeps a shadow
            rdata_next[`BWS_BIT_ENABLE]    = ctrl_reg.enable;
            rdata_next[`BWS_BIT_REFRESH]   = ctrl_reg.refresh;
            rdata_next[`BWS_BIT_BATT_GOOD] = power_fail_indication_n;
        end else if (!oe_next) begin
            rdata_next = `BWS_DATA_ZERO;
        end
        // Level, held while power-fail stays low
        chk_next    = nmi_route_reg & ~power_fail_indication_n;
        active_next = wdt_run;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rdata_reg  <= `BWS_DATA_ZERO;
            oe_reg     <= 1'b0;
            chk_reg    <= 1'b0;
            active_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            oe_reg     <= oe_next;
            chk_reg    <= chk_next;
            active_reg <= active_next;
        end
    end

    assign isa_data_o  = rdata_reg;
    assign isa_data_oe = oe_reg;
    assign iochk_n_o   = 1'b0;
    assign iochk_oe    = chk_reg;
    assign wdt_active  = active_reg;

endmodule

// ---- test/bws_properties.sv ----
// Port checker for the board watchdog supervisor top module.
// Assumes straps change only while rstn is low.
`timescale 1ns/1ns
`include "bws_defs.svh"

module bws_properties
    import bws_pkg::*;
#(
    parameter int unsigned PULSE_CYC = `BWS_RST_PULSE_CYC
) (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rstn,
    // ISA I/O bus
    input wire logic [9:0] isa_addr,
    input wire logic       isa_aen,
    input wire logic       isa_iow_n,
    input wire logic       isa_ior_n,
    input wire logic [7:0] isa_data_o,
    input wire logic       isa_data_oe,
    input wire logic       iochk_n_o,
    input wire logic       iochk_oe,
    // Straps and supervisor inputs
    input wire logic       watchdog_permit_strap,
    input wire logic [1:0] base_select_strap,
    input wire logic       nmi_route_strap,
    input wire logic       power_fail_indication_n,
    input wire logic       pushbutton_reset_n,
    input wire logic       supply_reset_n,
    // Results
    input wire logic       sys_reset_n,
    input wire logic       wdt_active
);
    logic [9:0] base;
    logic [7:0] low_cnt;
    logic       wd_flag;

    assign base = (base_select_strap == `BWS_STRAP_BASE_1) ? `BWS_BASE_1 :
                  (base_select_strap == `BWS_STRAP_BASE_2) ? `BWS_BASE_2 : `BWS_BASE_0;

    // ----------------------------------------------------------------
    // Pulse length tracking
    // ----------------------------------------------------------------
    // Flag remembers whether both buttons stayed idle from before the reset began until now
    always_ff @(posedge sys_clk) begin
        low_cnt <= (!rstn || sys_reset_n) ? 8'h00 : low_cnt + 8'h01;
        wd_flag <= rstn && pushbutton_reset_n && supply_reset_n && (sys_reset_n || wd_flag);
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    permit_gate_a: assert property (wdt_active |-> watchdog_permit_strap)
        else $error("watchdog active without permit");
    reset_idle_a: assert property ($rose(rstn) |-> !wdt_active && !isa_data_oe)
        else $error("not idle after reset");
    reset_clears_a: assert property (!sys_reset_n [*3] |-> !wdt_active)
        else $error("watchdog survives system reset");
    read_status_a: assert property ($fell(isa_ior_n) && isa_iow_n && !isa_aen &&
        isa_addr == base |=> isa_data_oe && isa_data_o[7:2] ==
        {4'h0, $past(power_fail_indication_n), 1'b0}) else $error("bad status read");
    foreign_addr_a: assert property ($fell(isa_ior_n) && (isa_addr != base || isa_aen)
        && !isa_data_oe |=> !isa_data_oe) else $error("foreign read answered");
    nmi_route_a: assert property ($past(rstn) |-> !iochk_n_o && iochk_oe ==
        $past(nmi_route_strap && !power_fail_indication_n)) else $error("bad nmi level");
    button_reset_a: assert property (!pushbutton_reset_n |=> !sys_reset_n)
        else $error("button reset missed");
    supply_reset_a: assert property (!supply_reset_n |=> !sys_reset_n)
        else $error("supply reset missed");
    wd_cause_a: assert property ($fell(sys_reset_n) && $past(pushbutton_reset_n) &&
        $past(supply_reset_n) |-> $past(wdt_active)) else $error("reset while idle");
    pulse_len_a: assert property ($rose(sys_reset_n) && wd_flag |->
        low_cnt == 8'(PULSE_CYC)) else $error("bad reset pulse length");
endmodule

bind bws_top bws_properties #(.PULSE_CYC(PULSE_CYC)) u_bws_properties (
    .sys_clk(sys_clk), .rstn(rstn), .isa_addr(isa_addr), .isa_aen(isa_aen),
    .isa_iow_n(isa_iow_n), .isa_ior_n(isa_ior_n), .isa_data_o(isa_data_o),
    .isa_data_oe(isa_data_oe), .iochk_n_o(iochk_n_o), .iochk_oe(iochk_oe),
    .watchdog_permit_strap(watchdog_permit_strap), .base_select_strap(base_select_strap),
    .nmi_route_strap(nmi_route_strap), .power_fail_indication_n(power_fail_indication_n),
    .pushbutton_reset_n(pushbutton_reset_n), .supply_reset_n(supply_reset_n),
    .sys_reset_n(sys_reset_n), .wdt_active(wdt_active));

// ---- test/bws_host.sv ----
// Host processor model: ISA I/O cycles and watchdog software with shadow.
// Assumes one cycle per call; the caller picks the register base.
`timescale 1ns/1ns

module bws_host (
    // Clock
    input  wire logic       sys_clk,
    // ISA I/O bus
    output logic      [9:0] isa_addr,
    output logic            isa_aen,
    output logic            isa_iow_n,
    output logic            isa_ior_n,
    output logic      [7:0] isa_data_i,
    input  wire logic [7:0] isa_data_o,
    input  wire logic       isa_data_oe
);
    // Control bits read back for diagnostics only, so writes come from here
    logic [7:0] shadow;

    initial begin
        isa_addr   = 10'h000;
        isa_aen    = 1'b0;
        isa_iow_n  = 1'b1;
        isa_ior_n  = 1'b1;
        isa_data_i = 8'h00;
        shadow     = 8'h00;
    end

    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        isa_addr   <= a;
        isa_data_i <= d;
        isa_iow_n  <= 1'b0;
        @(posedge sys_clk);
        isa_iow_n  <= 1'b1;
        // Released data lines show garbage, not the last byte
        isa_data_i <= ~d;
        @(posedge sys_clk);
    endtask

    task automatic io_rd(input logic [9:0] a, input logic aen, input int hold,
                         output logic [7:0] d, output logic oe);
        @(posedge sys_clk);
        isa_addr  <= a;
        isa_aen   <= aen;
        isa_ior_n <= 1'b0;
        @(posedge sys_clk);
        #1;
        d  = isa_data_o;
        oe = isa_data_oe;
        repeat (hold) @(posedge sys_clk);
        @(posedge sys_clk);
        isa_ior_n <= 1'b1;
        isa_aen   <= 1'b0;
        @(posedge sys_clk);
    endtask

    // ----------------------------------------------------------------
    // Watchdog software
    // ----------------------------------------------------------------
    task automatic sw_forget();
        shadow = 8'h00;
    endtask

    task automatic sw_write(input logic [9:0] base);
        io_wr(base, shadow);
    endtask

    task automatic sw_enable(input logic [9:0] base);
        shadow[0] = 1'b1;
        io_wr(base, shadow);
    endtask

    task automatic sw_refresh(input logic [9:0] base);
        shadow[1] = ~shadow[1];
        io_wr(base, shadow);
    endtask
endmodule

// ---- test/board_watchdog_supervisor_tb.sv ----
// Testbench for the board watchdog supervisor top module.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`include "bws_defs.svh"

module board_watchdog_supervisor_tb;
    localparam longint unsigned TO    = 64'd50;
    localparam int unsigned     PULSE = 16;

    logic       sys_clk, rstn, watchdog_permit_strap, nmi_route_strap;
    logic [1:0] base_select_strap;
    logic       power_fail_indication_n, pushbutton_reset_n, supply_reset_n;
    logic [9:0] isa_addr, base;
    logic [7:0] isa_data_i, isa_data_o, rd;
    logic       isa_aen, isa_iow_n, isa_ior_n, isa_data_oe, oe;
    logic       iochk_n_o, iochk_oe, sys_reset_n, wdt_active;
    int         n_errors, total_checks, cnt;

    bws_host u_bws_host (.sys_clk(sys_clk), .isa_addr(isa_addr), .isa_aen(isa_aen),
        .isa_iow_n(isa_iow_n), .isa_ior_n(isa_ior_n), .isa_data_i(isa_data_i),
        .isa_data_o(isa_data_o), .isa_data_oe(isa_data_oe));

    bws_top #(.TIMEOUT_CYC(TO), .PULSE_CYC(PULSE)) u_bws_top (
        .sys_clk(sys_clk), .rstn(rstn), .isa_addr(isa_addr), .isa_aen(isa_aen),
        .isa_iow_n(isa_iow_n), .isa_ior_n(isa_ior_n), .isa_data_i(isa_data_i),
        .isa_data_o(isa_data_o), .isa_data_oe(isa_data_oe), .iochk_n_o(iochk_n_o),
        .iochk_oe(iochk_oe), .watchdog_permit_strap(watchdog_permit_strap),
        .base_select_strap(base_select_strap), .nmi_route_strap(nmi_route_strap),
        .power_fail_indication_n(power_fail_indication_n),
        .pushbutton_reset_n(pushbutton_reset_n), .supply_reset_n(supply_reset_n),
        .sys_reset_n(sys_reset_n), .wdt_active(wdt_active));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    function automatic logic [9:0] exp_base(input logic [1:0] b);
        case (b)
            `BWS_STRAP_BASE_1: return `BWS_BASE_1;
            `BWS_STRAP_BASE_2: return `BWS_BASE_2;
            default:           return `BWS_BASE_0;
        endcase
    endfunction

    task automatic do_reset(input logic p, input logic [1:0] b, input logic n);
        @(posedge sys_clk);
        rstn                  <= 1'b0;
        watchdog_permit_strap <= p;
        base_select_strap     <= b;
        nmi_route_strap       <= n;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        base = exp_base(b);
        u_bws_host.sw_forget();
    endtask

    // Bounded wait, counting cycles until sys_reset_n reaches the level
    task automatic wait_lvl(input logic lvl, output int n);
        n = 0;
        while (sys_reset_n !== lvl && n < 500) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Run takes a few hundred cycles; this cuts a hang short
    initial begin
        #100000;
        n_errors++;
        final_report();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        watchdog_permit_strap = 1'b1;
        base_select_strap = 2'h0;
        nmi_route_strap = 1'b0;
        power_fail_indication_n = 1'b1;
        pushbutton_reset_n = 1'b1;
        supply_reset_n = 1'b1;
        n_errors = 0;
        total_checks = 0;
        for (int i = 0; i < 4; i++) begin
            do_reset(1'b1, 2'(i), 1'b0);
            u_bws_host.io_rd(base, 1'b0, i, rd, oe);
            chk({7'h00, oe}, 8'h01);
            chk(rd, 8'h08);
            u_bws_host.io_rd(base + 10'h100, 1'b0, 0, rd, oe);
            chk({7'h00, oe}, 8'h00);
        end
        u_bws_host.io_rd(base, 1'b1, 0, rd, oe);
        chk({7'h00, oe}, 8'h00);
        @(posedge sys_clk);
        power_fail_indication_n <= 1'b0;
        u_bws_host.io_rd(base, 1'b0, 0, rd, oe);
        chk(rd, 8'h00);
        chk({7'h00, iochk_oe}, 8'h00);
        do_reset(1'b1, 2'h0, 1'b1);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({7'h00, iochk_oe}, 8'h01);
        @(posedge sys_clk);
        power_fail_indication_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({7'h00, iochk_oe}, 8'h00);
        do_reset(1'b0, 2'h0, 1'b0);
        u_bws_host.sw_enable(base);
        repeat (TO + 20) @(posedge sys_clk);
        #1;
        chk({6'h00, wdt_active, sys_reset_n}, 8'h01);
        do_reset(1'b1, 2'h1, 1'b0);
        u_bws_host.sw_enable(base);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({7'h00, wdt_active}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            repeat (30) @(posedge sys_clk);
            u_bws_host.sw_refresh(base);
            chk({7'h00, sys_reset_n}, 8'h01);
        end
        u_bws_host.io_rd(base, 1'b0, 0, rd, oe);
        chk(rd, 8'h09);
        u_bws_host.sw_refresh(base);
        repeat (20) @(posedge sys_clk);
        u_bws_host.sw_write(base);
        wait_lvl(1'b0, cnt);
        chk({7'h00, cnt >= TO - 30 && cnt <= TO - 20}, 8'h01);
        wait_lvl(1'b1, cnt);
        chk(8'(cnt), 8'(PULSE));
        chk({7'h00, wdt_active}, 8'h00);
        u_bws_host.sw_forget();
        u_bws_host.io_rd(base, 1'b0, 0, rd, oe);
        chk(rd & 8'h01, 8'h00);
        for (int k = 0; k < 2; k++) begin
            u_bws_host.sw_enable(base);
            @(posedge sys_clk);
            pushbutton_reset_n <= (k != 0);
            supply_reset_n     <= (k == 0);
            repeat (3) @(posedge sys_clk);
            #1;
            chk({7'h00, sys_reset_n}, 8'h00);
            @(posedge sys_clk);
            pushbutton_reset_n <= 1'b1;
            supply_reset_n     <= 1'b1;
            repeat (3) @(posedge sys_clk);
            #1;
            chk({6'h00, sys_reset_n, wdt_active}, 8'h02);
            u_bws_host.sw_forget();
        end
        final_report();
    end
endmodule
